//--- rtl/sbm_pkg.sv
package sbm_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] DATA_IDX  = 12'h060;
    localparam logic [11:0] CTRL_IDX  = 12'h061;
    localparam logic [11:0] DATA_ADDR = 12'(DATA_IDX * 4);
    localparam logic [11:0] CTRL_ADDR = 12'(CTRL_IDX * 4);
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [1:0]  RESP_OKAY = 2'h0;
    localparam logic [1:0]  RESP_SLVE = 2'h2;

    // Control register fields
    localparam int CTRL_DONE_BIT = 7;
    localparam int CTRL_FULL_BIT = 6;
    localparam int CTRL_ROLE_LSB = 4;
    localparam int CTRL_POL_BIT  = 3;
    localparam int CTRL_PHA_BIT  = 2;
    localparam int CTRL_RATE_LSB = 0;

    // Role field codes
    localparam logic [1:0] ROLE_OFF    = 2'h0;
    localparam logic [1:0] ROLE_MASTER = 2'h1;
    localparam logic [1:0] ROLE_SLAVE  = 2'h2;

    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] PULSES   = 4'h8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ   = 125;
    localparam int PER0_NS   = 500;
    localparam int PER1_NS   = 1000;
    localparam int PER2_NS   = 2000;
    localparam int PER3_NS   = 16000;
    localparam int BIT0_CYC  = (PER0_NS * CLK_MHZ + 999) / 1000;
    localparam int BIT1_CYC  = (PER1_NS * CLK_MHZ + 999) / 1000;
    localparam int BIT2_CYC  = (PER2_NS * CLK_MHZ + 999) / 1000;
    localparam int BIT3_CYC  = (PER3_NS * CLK_MHZ + 999) / 1000;
    // Fastest rate holds the clock active for a third of the bit
    localparam int ACT0_CYC  = BIT0_CYC / 3;
    localparam int ACT1_CYC  = BIT1_CYC / 2;
    localparam int ACT2_CYC  = BIT2_CYC / 2;
    localparam int ACT3_CYC  = BIT3_CYC / 2;

endpackage

//--- rtl/sbm_sync.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ------------------------------------------------------------
module sbm_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage is read by the second stage only
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

//--- rtl/sbm_clkgen.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Master serial clock timing: idle phase then active phase
// ------------------------------------------------------------
module sbm_clkgen import sbm_pkg::*; (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Control
    input  wire logic       run,
    input  wire logic [1:0] rate_sel,
    // Timing events
    output logic            lead_tick,
    output logic            trail_tick,
    output logic            act_q
);

    logic [15:0] cnt_q;
    logic [15:0] idle_len;
    logic [15:0] act_len;

    // Phase lengths per rate code
    always_comb begin
        case (rate_sel)
            2'h0: begin
                act_len = 16'(ACT0_CYC);
                idle_len = 16'(BIT0_CYC - ACT0_CYC);
            end
            2'h1: begin
                act_len = 16'(ACT1_CYC);
                idle_len = 16'(BIT1_CYC - ACT1_CYC);
            end
            2'h2: begin
                act_len = 16'(ACT2_CYC);
                idle_len = 16'(BIT2_CYC - ACT2_CYC);
            end
            default: begin
                act_len = 16'(ACT3_CYC);
                idle_len = 16'(BIT3_CYC - ACT3_CYC);
            end
        endcase
    end

    assign lead_tick  = run && !act_q && (cnt_q == idle_len - 16'h0001);
    assign trail_tick = run && act_q && (cnt_q == act_len - 16'h0001);

    // Counter restarts whenever the engine stops
    always_ff @(posedge core_clk) begin
        if (sys_rst || !run) begin
            cnt_q <= 16'h0000;
            act_q <= 1'b0;
        end else if (lead_tick || trail_tick) begin
            cnt_q <= 16'h0000;
            act_q <= lead_tick;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

endmodule

//--- rtl/sbm_top.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
// ------------------------------------------------------------
// Byte-serial SPI engine with AXI4-Lite registers
// ------------------------------------------------------------
module sbm_top import sbm_pkg::*; #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Serial pins
    input  wire logic              sck_i,
    output logic                   sck_o,
    output logic                   sck_oe,
    input  wire logic              mosi_i,
    output logic                   mosi_o,
    output logic                   mosi_oe,
    input  wire logic              miso_i,
    output logic                   miso_o,
    output logic                   miso_oe,
    input  wire logic              ss_n_i,
    // Interrupt request
    output logic                   spi_irq
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0]  tx_q;
    logic [7:0]  rx_q;
    logic        transmit_buffer_full_flag_q;
    logic        transfer_complete_flag_q;
    logic [1:0]  role_q;
    logic        clock_polarity_select_q;
    logic        clock_phase_select_q;
    logic [1:0]  rate_sel_q;

    logic              aw_full_q;
    logic              w_full_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [7:0]        w_byte_q;
    logic              w_lane0_q;

    logic [7:0]  sr_q;
    logic [2:0]  bit_cnt_q;
    logic        busy_q;
    logic        samp_q;
    logic        sck_prev_q;
    logic        ss_prev_q;
    logic [3:0]  lead_cnt_q;

    logic [3:0]  pin_s;
    logic        sck_s;
    logic        mosi_s;
    logic        miso_s;
    logic        ss_n_s;
    logic        cg_lead;
    logic        cg_trail;
    logic        cg_act;

    // ------------------------------------------------------------
    // Pin synchronisers and clock timing
    // ------------------------------------------------------------
    sbm_sync #(
        .WIDTH    (4)
    ) u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .async_in ({sck_i, mosi_i, miso_i, ss_n_i}),
        .sync_out (pin_s)
    );

    assign sck_s  = pin_s[3];
    assign mosi_s = pin_s[2];
    assign miso_s = pin_s[1];
    assign ss_n_s = pin_s[0];

    logic is_master;
    logic is_slave;
    assign is_master = (role_q == ROLE_MASTER);
    assign is_slave  = (role_q == ROLE_SLAVE);

    sbm_clkgen u_clkgen (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .run        (is_master && busy_q),
        .rate_sel   (rate_sel_q),
        .lead_tick  (cg_lead),
        .trail_tick (cg_trail),
        .act_q      (cg_act)
    );

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic wr_fire;
    logic data_wr;
    logic ctrl_wr;
    logic [7:0] ctrl_rd;
    assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
    assign data_wr = wr_fire && w_lane0_q && (aw_addr_q[11:2] == DATA_ADDR[11:2]);
    assign ctrl_wr = wr_fire && w_lane0_q && (aw_addr_q[11:2] == CTRL_ADDR[11:2]);
    assign ctrl_rd = {transfer_complete_flag_q, transmit_buffer_full_flag_q, role_q,
                      clock_polarity_select_q, clock_phase_select_q, rate_sel_q};

    // Address and data are taken independently, in either order
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            aw_addr_q     <= '0;
            w_byte_q      <= RST_BYTE;
            w_lane0_q     <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q     <= s_axi_awaddr;
                aw_full_q     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_byte_q     <= s_axi_wdata[7:0];
                w_lane0_q    <= s_axi_wstrb[0];
                w_full_q     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_full_q    <= 1'b0;
                w_full_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_q[11:2] == DATA_ADDR[11:2] ||
                                 aw_addr_q[11:2] == CTRL_ADDR[11:2]) ? RESP_OKAY : RESP_SLVE;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            if (s_axi_araddr[11:2] == DATA_ADDR[11:2]) begin
                s_axi_rdata <= {24'h00_0000, rx_q};
                s_axi_rresp <= RESP_OKAY;
            end else if (s_axi_araddr[11:2] == CTRL_ADDR[11:2]) begin
                s_axi_rdata <= {24'h00_0000, ctrl_rd};
                s_axi_rresp <= RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= RESP_SLVE;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Control fields; the full flag is hardware-owned and ignores writes
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            role_q                  <= ROLE_OFF;
            clock_polarity_select_q <= 1'b0;
            clock_phase_select_q    <= 1'b0;
            rate_sel_q              <= 2'h0;
        end else if (ctrl_wr) begin
            role_q                  <= w_byte_q[CTRL_ROLE_LSB +: 2];
            clock_polarity_select_q <= w_byte_q[CTRL_POL_BIT];
            clock_phase_select_q    <= w_byte_q[CTRL_PHA_BIT];
            rate_sel_q              <= w_byte_q[CTRL_RATE_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // Serial events
    // ------------------------------------------------------------
    logic s_sel;
    logic s_lead;
    logic lead;
    logic trail;
    logic in_bit;
    logic done_ev;
    logic ss_fall;
    logic load_ev;
    logic abort;
    logic sck_chg;

    assign sck_chg = sck_s != sck_prev_q;
    assign s_sel   = is_slave && !ss_n_s;
    assign s_lead  = s_sel && sck_chg && (sck_s != clock_polarity_select_q);
    assign lead    = (is_master && busy_q && cg_lead) || s_lead;
    assign trail   = (is_master && busy_q && cg_trail) ||
                     (s_sel && sck_chg && (sck_s == clock_polarity_select_q));
    assign in_bit  = is_master ? miso_s : mosi_s;
    assign done_ev = trail && busy_q && (bit_cnt_q == BIT_LAST);
    assign ss_fall = is_slave && ss_prev_q && !ss_n_s;
    // Idle master loads at once, busy one waits for the byte end
    assign load_ev = ss_fall || (transmit_buffer_full_flag_q &&
                     (is_master ? (!busy_q || done_ev) :
                      (s_sel && ((!busy_q && !lead) || done_ev))));
    assign abort   = busy_q && (!(is_master || is_slave) || (is_slave && ss_n_s));

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sck_prev_q <= 1'b0;
            ss_prev_q  <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            ss_prev_q  <= ss_n_s;
        end
    end

    // ------------------------------------------------------------
    // Transmit buffer
    // ------------------------------------------------------------
    // A write in the same cycle as the copy wins, so no byte is lost
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tx_q                        <= RST_BYTE;
            transmit_buffer_full_flag_q <= 1'b0;
        end else begin
            if (load_ev) begin
                transmit_buffer_full_flag_q <= 1'b0;
            end
            if (data_wr) begin
                tx_q                        <= w_byte_q;
                transmit_buffer_full_flag_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------
    // Phase 0 samples on lead and shifts on trail; phase 1 swaps them
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sr_q      <= RST_BYTE;
            bit_cnt_q <= 3'h0;
            busy_q    <= 1'b0;
            samp_q    <= 1'b0;
        end else if (abort) begin
            busy_q    <= 1'b0; // Role neither master nor slave, or slave select lost: byte dropped
            bit_cnt_q <= 3'h0;
        end else begin
            if (clock_phase_select_q ? trail : lead) begin
                samp_q <= in_bit;
            end
            if (clock_phase_select_q ? (lead && bit_cnt_q != 3'h0) : trail) begin
                sr_q <= {sr_q[6:0], samp_q};
            end
            if (trail) begin
                bit_cnt_q <= done_ev ? 3'h0 : bit_cnt_q + 3'h1;
            end
            if (load_ev) begin
                sr_q <= tx_q;
            end
            if (done_ev && !(is_master && load_ev)) begin
                busy_q <= 1'b0;
            end else if ((is_master && load_ev) || s_lead) begin
                busy_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Receive buffer and completion
    // ------------------------------------------------------------
    // Clear by writing 0 to the flag bit; a same-cycle completion wins
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rx_q                     <= RST_BYTE;
            transfer_complete_flag_q <= 1'b0;
            spi_irq                  <= 1'b0;
        end else begin
            spi_irq <= done_ev;
            if (ctrl_wr && !w_byte_q[CTRL_DONE_BIT]) begin
                transfer_complete_flag_q <= 1'b0;
            end
            if (done_ev) begin
                rx_q <= {sr_q[6:0], clock_phase_select_q ? in_bit : samp_q};
                transfer_complete_flag_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // Slave select is left to firmware on a spare port pin
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sck_o   <= 1'b0;
            sck_oe  <= 1'b0;
            mosi_o  <= 1'b0;
            mosi_oe <= 1'b0;
            miso_o  <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            sck_o   <= clock_polarity_select_q ^ (busy_q && cg_act);
            sck_oe  <= is_master;
            mosi_o  <= sr_q[7];
            mosi_oe <= is_master;
            miso_o  <= sr_q[7];
            miso_oe <= s_sel;
        end
    end

    // Counts leading edges within one byte for checking
    always_ff @(posedge core_clk) begin
        if (sys_rst || !busy_q || done_ev) begin
            lead_cnt_q <= 4'h0;
        end else if (lead) begin
            lead_cnt_q <= lead_cnt_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_irq_with_flag:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        spi_irq |-> transfer_complete_flag_q && $past(done_ev))
    else $error("Interrupt without complete flag");

    a_off_stays_idle:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        (role_q == ROLE_OFF) ##1 (role_q == ROLE_OFF) |-> !busy_q && !spi_irq)
    else $error("Engine active with role off");

    a_sck_idle_level:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        (!busy_q && $past(!busy_q) && is_master) |-> sck_o == $past(clock_polarity_select_q))
    else $error("Serial clock not at idle level");

    a_tbf_clear_load:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        (load_ev && !data_wr) |=> !transmit_buffer_full_flag_q)
    else $error("Full flag stuck after copy");

    a_write_sets_tbf:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        data_wr |=> transmit_buffer_full_flag_q && (tx_q == $past(w_byte_q)))
    else $error("Data write did not load transmit buffer");

    a_start_from_write:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        (is_master && $rose(busy_q)) |-> $past(transmit_buffer_full_flag_q))
    else $error("Master started without a written byte");

    a_eight_pulses:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        (done_ev && is_master) |-> lead_cnt_q == PULSES)
    else $error("Byte ended with wrong pulse count");

    a_done_moves_rx:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        done_ev |=> (rx_q == {$past(sr_q[6:0]), $past(clock_phase_select_q) ?
                      $past(in_bit) : $past(samp_q)}) ##1 !spi_irq || done_ev)
    else $error("Receive buffer not updated at byte end");

endmodule

//--- tb/sbm_slave_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Behavioural serial slave on the far side of the engine
// ------------------------------------------------------------
module sbm_slave_model (
    // Serial lines
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       ss_n,
    output logic            miso,
    // Mode and data
    input  wire logic       pol,
    input  wire logic       pha,
    input  wire logic [7:0] tx,
    output logic      [7:0] sh
);
    logic ss_p;
    logic sck_p;
    // One process owns both lines, so no value has two writers
    initial begin
        {miso, ss_p, sck_p} = 3'b010;
        forever begin
            @(ss_n or sck);
            if (ss_n !== ss_p) begin
                // Load on select; a released line shows the inverse, never a held value
                if (!ss_n) sh = tx;
                miso = ss_n ? ~miso : tx[7];
            end else if (!ss_n && sck !== sck_p) begin
                // Sample edge shifts in, the other edge presents the next bit
                if ((sck != pol) ^ pha) sh = {sh[6:0], mosi};
                else miso = sh[7];
            end
            ss_p = ss_n;
            sck_p = sck;
        end
    end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import sbm_pkg::*; ();
    logic        core_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, sck_o, sck_oe, mosi_o, mosi_oe, miso_oe, spi_irq;
    logic        miso, ss_n, pol, pha;
    logic        sck_p = 1'b0;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  stx, srx, tx;
    int          fail_count, samples_checked;
    int          cyc = 0, leads = 0, act_n = 0, gap = 0, tprev = 0;

    sbm_top DUT (.core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck_i(1'b0), .sck_o,
        .sck_oe, .mosi_i(1'b0), .mosi_o, .mosi_oe, .miso_i(miso), .miso_o(),
        .miso_oe, .ss_n_i(1'b1), .spi_irq);
    // Data input pin wired as a plain input; port bits are not modelled
    sbm_slave_model SLV (.sck(sck_o), .mosi(mosi_o), .ss_n(ss_n), .miso(miso),
        .pol(pol), .pha(pha), .tx(stx), .sh(srx));

    // ------------------------------------------------------------
    // Clock and serial clock monitor
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Counts leading edges, active cycles and the gap between leading edges
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        sck_p <= sck_o;
        // Pins are unknown until the first reset edge, so reset time is skipped
        if (!sys_rst && sck_o !== pol) act_n <= act_n + 1;
        if (!sys_rst && sck_o !== sck_p && sck_o !== pol) begin
            leads <= leads + 1;
            gap <= cyc - tprev;
            tprev <= cyc;
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Address and data offered together, each released once taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk(s_axi_bresp, RESP_OKAY, "write resp");
        s_axi_bready <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, exp, "read data");
        chk(s_axi_rresp, er, "read resp");
        s_axi_rready <= 1'b0;
    endtask
    task automatic wait_irq();
        int n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (spi_irq !== 1'b1 && n < 20000);
        chk(n < 20000, 1, "no irq");
    endtask
    function automatic int bitc(input logic [1:0] t, input bit act);
        int b = t == 0 ? BIT0_CYC : t == 1 ? BIT1_CYC : t == 2 ? BIT2_CYC : BIT3_CYC;
        int h = t == 0 ? ACT0_CYC : t == 1 ? ACT1_CYC : t == 2 ? ACT2_CYC : ACT3_CYC;
        return act ? h : b;
    endfunction
    // One master byte in a given mode and rate, with a random byte from the slave
    task automatic xfer(input logic [1:0] md, input logic [1:0] rt);
        logic [7:0] c;
        int         l0, a0;
        c = {2'h0, ROLE_MASTER, md, rt};
        pol = md[1];
        pha = md[0];
        wr(CTRL_ADDR, c);
        // Let the new idle level reach the pin before counting
        @(posedge core_clk);
        l0 = leads;
        a0 = act_n;
        tx = 8'($urandom);
        stx = 8'($urandom);
        ss_n = 1'b0;
        wr(DATA_ADDR, tx);
        wait_irq();
        rchk(DATA_ADDR, stx, RESP_OKAY);
        // In phase 1 the slave's last sample edge on the pin lags the interrupt
        chk(srx, tx, "slave got");
        rchk(CTRL_ADDR, c | 8'h80, RESP_OKAY);
        wr(CTRL_ADDR, c);
        rchk(CTRL_ADDR, c, RESP_OKAY);
        chk(leads - l0, 8, "pulses");
        chk(act_n - a0, 8 * bitc(rt, 1), "active");
        chk(gap, bitc(rt, 0), "bit time");
        chk(sck_o, pol, "idle level");
        ss_n = 1'b1;
    endtask
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, stx} = '0;
        {fail_count, samples_checked} = '0;
        {pol, pha} = '0;
        s_axi_wstrb = 4'hf;
        sys_rst = 1'b1;
        ss_n = 1'b1;
        void'($urandom(45134));
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        rchk(DATA_ADDR, 32'(RST_BYTE), RESP_OKAY);
        rchk(CTRL_ADDR, 0, RESP_OKAY);
        rchk(12'h000, 0, RESP_SLVE);
        // Every role code; only master drives the clock pin
        for (int i = 0; i < 4; i++) begin
            wr(CTRL_ADDR, 8'(i << 4));
            @(posedge core_clk);
            chk({sck_oe, mosi_oe, miso_oe}, i == 1 ? 3'h6 : 3'h0, "enables");
        end
        chk(leads, 0, "spurious start");
        for (int i = 0; i < 4; i++) xfer(2'(i), 2'(i));
        // Pending byte replaced while busy, then sent back to back
        pol = 1'b0;
        pha = 1'b0;
        wr(CTRL_ADDR, {2'h0, ROLE_MASTER, 4'h0});
        ss_n = 1'b0;
        b1 = 8'($urandom);
        tx = 8'($urandom);
        wr(DATA_ADDR, b1);
        wr(DATA_ADDR, 8'h00);
        rchk(CTRL_ADDR, 8'h50, RESP_OKAY);
        wr(DATA_ADDR, tx);
        wait_irq();
        chk(srx, b1, "first byte");
        wait_irq();
        chk(srx, tx, "pending byte");
        rchk(DATA_ADDR, b1, RESP_OKAY);
        ss_n = 1'b1;
        end_sim();
    end
    // Watchdog over the expected run length
    initial begin
        repeat (40000) @(posedge core_clk);
        fail_count++;
        end_sim();
    end
endmodule
